// >>> rtl/op_exec_pkg.sv
// shared constants for the bit-test, clear and complement execution block
package op_exec_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int BIT_W = 3;
	localparam int INSTR_W = 16;
	// instruction word layout
	localparam int OPC_HI = 15;
	localparam int OPC_LO = 11;
	localparam int DEST_POS = 10;
	localparam int BIT_HI = 9;
	localparam int BIT_LO = 7;
	localparam int ADDR_HI = 6;
	localparam int ADDR_LO = 0;
	localparam logic [4:0] OPC_TEST_BIT_SKIP_IF_SET = 5'h01;
	localparam logic [4:0] OPC_CLEAR_ACCUMULATOR = 5'h02;
	localparam logic [4:0] OPC_CLEAR_REGISTER = 5'h03;
	localparam logic [4:0] OPC_COMPLEMENT_REGISTER = 5'h04;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] ACC_RESET = 8'h00;
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_TEST_BIT_SKIP_IF_SET = 3'h1,
		OP_CLEAR_ACCUMULATOR = 3'h2,
		OP_CLEAR_REGISTER = 3'h3,
		OP_COMPLEMENT_REGISTER = 3'h4
	} op_t;
	typedef enum logic [0:0] {
		ST_RUN = 1'b0,
		ST_SKIP = 1'b1
	} exec_state_t;
endpackage

// >>> rtl/decode_if.sv
// decoded instruction fields passed from decoder to executer
`timescale 1ns/1ps
interface decode_if;
	op_exec_pkg::op_t op;
	logic [op_exec_pkg::ADDR_W-1:0] addr;
	logic [op_exec_pkg::BIT_W-1:0] bit_sel;
	logic dest;
	modport dec(output op, output addr, output bit_sel, output dest);
	modport exe(input op, input addr, input bit_sel, input dest);
endinterface

// >>> rtl/instr_decoder.sv
// instruction word field decoder
`timescale 1ns/1ps
module instr_decoder (
	input wire logic [op_exec_pkg::INSTR_W-1:0] i_instr,
	input wire logic i_valid,
	decode_if.dec d
);
	logic [4:0] opc;
	always_comb begin
		opc = i_instr[op_exec_pkg::OPC_HI:op_exec_pkg::OPC_LO];
		d.addr = i_instr[op_exec_pkg::ADDR_HI:op_exec_pkg::ADDR_LO];
		d.bit_sel = i_instr[op_exec_pkg::BIT_HI:op_exec_pkg::BIT_LO];
		d.dest = i_instr[op_exec_pkg::DEST_POS];
		d.op = op_exec_pkg::OP_NONE;
		if (i_valid) begin
			case (opc)
				op_exec_pkg::OPC_TEST_BIT_SKIP_IF_SET: d.op = op_exec_pkg::OP_TEST_BIT_SKIP_IF_SET;
				op_exec_pkg::OPC_CLEAR_ACCUMULATOR: d.op = op_exec_pkg::OP_CLEAR_ACCUMULATOR;
				op_exec_pkg::OPC_CLEAR_REGISTER: d.op = op_exec_pkg::OP_CLEAR_REGISTER;
				op_exec_pkg::OPC_COMPLEMENT_REGISTER: d.op = op_exec_pkg::OP_COMPLEMENT_REGISTER;
				default: d.op = op_exec_pkg::OP_NONE;
			endcase
		end
	end
endmodule

// >>> rtl/op_exec.sv
// execution of bit-test-skip, clear and complement instructions
//
// Behaviour
// - skip next instruction when tested bit set
// - skip discards fetched instruction; two cycles
// - clear accumulator writes zero, sets zero flag
// - clear register writes zero, sets zero flag
// - complement inverts register, updates zero flag only
// - destination zero writes complement result to accumulator; clear register ignores destination and always writes register
// - destination one writes result back register
`timescale 1ns/1ps
module op_exec (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [op_exec_pkg::INSTR_W-1:0] i_instr,
	input wire logic i_instr_valid,
	input wire logic [op_exec_pkg::DATA_W-1:0] i_mem_rdata,
	output logic [op_exec_pkg::ADDR_W-1:0] o_mem_addr,
	output logic [op_exec_pkg::DATA_W-1:0] o_mem_wdata,
	output logic o_mem_we,
	output logic [op_exec_pkg::DATA_W-1:0] o_accumulator,
	output logic o_zero_flag,
	output logic o_skip,
	output logic o_busy
);
	decode_if dbus();
	instr_decoder u_dec (
		.i_instr(i_instr),
		.i_valid(i_instr_valid),
		.d(dbus.dec)
	);

	op_exec_pkg::exec_state_t state_reg, state_next;
	logic [op_exec_pkg::DATA_W-1:0] acc_reg, acc_next;
	logic zero_reg, zero_next;
	logic [op_exec_pkg::DATA_W-1:0] inv;
	logic act;

	// memory read address follows the decoded operand combinationally
	assign o_mem_addr = dbus.addr;
	assign o_accumulator = acc_reg;
	assign o_zero_flag = zero_reg;
	assign o_busy = (state_reg == op_exec_pkg::ST_SKIP);
	assign o_skip = o_busy;

	always_comb begin
		inv = ~i_mem_rdata;
		// while discarding, the fetched word acts as a no-operation
		act = (state_reg == op_exec_pkg::ST_RUN);
		state_next = op_exec_pkg::ST_RUN;
		acc_next = acc_reg;
		zero_next = zero_reg;
		o_mem_we = 1'b0;
		o_mem_wdata = op_exec_pkg::ZERO_BYTE;
		if (act) begin
			case (dbus.op)
				op_exec_pkg::OP_TEST_BIT_SKIP_IF_SET: begin
					if (i_mem_rdata[dbus.bit_sel]) begin
						state_next = op_exec_pkg::ST_SKIP;
					end
				end
				op_exec_pkg::OP_CLEAR_ACCUMULATOR: begin
					acc_next = op_exec_pkg::ZERO_BYTE;
					zero_next = 1'b1;
				end
				op_exec_pkg::OP_CLEAR_REGISTER: begin
					o_mem_we = 1'b1;
					o_mem_wdata = op_exec_pkg::ZERO_BYTE;
					zero_next = 1'b1;
				end
				op_exec_pkg::OP_COMPLEMENT_REGISTER: begin
					zero_next = (inv == op_exec_pkg::ZERO_BYTE);
					if (dbus.dest) begin
						o_mem_we = 1'b1;
						o_mem_wdata = inv;
					end else begin
						acc_next = inv;
					end
				end
				default: begin
					state_next = op_exec_pkg::ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state_reg <= op_exec_pkg::ST_RUN;
			acc_reg <= op_exec_pkg::ACC_RESET;
			zero_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			acc_reg <= acc_next;
			zero_reg <= zero_next;
		end
	end
endmodule

// >>> verification/op_exec_monitor.sv
// concurrent checks on the execution block ports
`timescale 1ns/1ps
module op_exec_monitor (
	input wire logic i_core_clk, i_rst, i_instr_valid, o_mem_we, o_zero_flag, o_skip,
	input wire logic [15:0] i_instr,
	input wire logic [7:0] i_mem_rdata, o_mem_wdata, o_accumulator,
	input wire logic [6:0] o_mem_addr
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	wire go = i_instr_valid && !o_skip;
	wire [4:0] op = i_instr[15:11];
	sequence test_set;
		go && op == 5'h01 && i_mem_rdata[i_instr[9:7]];
	endsequence
	sequence comp_op;
		go && op == 5'h04;
	endsequence
	chk_skip_set: assert property (test_set |=> o_skip) else $error("no skip");
	chk_no_skip: assert property (go && op == 5'h01 && !i_mem_rdata[i_instr[9:7]] |=> !o_skip)
		else $error("skip on clear bit");
	chk_skip_drop: assert property (o_skip |-> !o_mem_we ##1 !o_skip) else $error("drop");
	chk_clear_acc: assert property (go && op == 5'h02 |=> o_accumulator == 8'h00 && o_zero_flag)
		else $error("clear_accumulator_op");
	chk_clear_reg: assert property (go && op == 5'h03 |-> o_mem_we && o_mem_wdata == 8'h00
		##1 o_zero_flag) else $error("clear_register_op");
	chk_comp_zero: assert property (comp_op |=> o_zero_flag == ($past(i_mem_rdata) == 8'hff))
		else $error("zero");
	chk_comp_acc: assert property ((comp_op and !i_instr[10]) |-> !o_mem_we
		##1 o_accumulator == ~$past(i_mem_rdata)) else $error("to acc");
	chk_comp_reg: assert property ((comp_op and i_instr[10]) |-> o_mem_we
		&& o_mem_wdata == ~i_mem_rdata ##1 $stable(o_accumulator)) else $error("to reg");
	chk_addr_field: assert property (o_mem_addr == i_instr[6:0]) else $error("addr");
endmodule
bind op_exec op_exec_monitor mon (.*);

// >>> verification/op_exec_bench.sv
// self-checking bench for the execution block
`timescale 1ns/1ps
module op_exec_bench;
	logic i_core_clk = 0, i_rst = 1, i_instr_valid = 0, o_mem_we, o_zero_flag, o_skip, o_busy;
	logic [15:0] i_instr = 16'h0000, w;
	logic [7:0] i_mem_rdata = 8'h00, o_mem_wdata, o_accumulator, r, wd, a, f;
	logic [6:0] o_mem_addr;
	int num_errors = 0, n_compared = 0;
	// instr, rdata, wdata, accumulator, {skip, zero}
	logic [47:0] rows [10] = '{48'h20050000ff00, 48'h247fa659ff00, 48'h18125500ff01,
		48'h2001ff000001, 48'h20025a00a500, 48'h100033000001, 48'h0983f7000001,
		48'h098308000003, 48'h200500000001, 48'h247f0ff00000};
	op_exec dut (.*);
	always #2.5 i_core_clk = ~i_core_clk;
	task chk(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task results;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge i_core_clk);
		#1 i_rst = 0;
		chk(o_accumulator, 8'h00);
		chk({o_skip, o_zero_flag}, 8'h00);
		// row 7 takes a skip, so row 8 must leave no trace
		for (int k = 0; k < 10; k++) begin
			{w, r, wd, a, f} = rows[k];
			i_instr = w;
			i_mem_rdata = r;
			i_instr_valid = 1;
			#1 chk(o_mem_wdata, wd);
			chk({7'h00, o_mem_we}, {7'h00, (w[15:11] == 5'h03 || (w[15:11] == 5'h04 && w[10])) && k != 8});
			chk({1'b0, o_mem_addr}, {1'b0, w[6:0]});
			@(posedge i_core_clk) #1 chk(o_accumulator, a);
			chk({o_skip, o_zero_flag}, f);
			chk({7'h00, o_busy}, {7'h00, o_skip});
		end
		// mid-run reset must clear a non-zero accumulator
		i_instr = 16'h2001;
		i_mem_rdata = 8'h00;
		@(posedge i_core_clk) #1 chk(o_accumulator, 8'hff);
		i_rst = 1;
		@(posedge i_core_clk) #1 i_rst = 0;
		chk(o_accumulator, 8'h00);
		chk({o_skip, o_zero_flag}, 8'h00);
		results;
	end
	initial begin
		#1000 num_errors++;
		results;
	end
endmodule
